// *** tdr_dev.sv ***
// tdr_dev: reconfiguration controller, device end of tdr_link_if
// assumes user logic on the same clock drives the link; resetn is power-up reset
module tdr_dev #(
  parameter int NCH = 4,
  parameter int LAST_ADDR = tdr_pkg::LAST_ADDR_DEF,
  parameter int CHW = (NCH > 1) ? $clog2(NCH) : 1
) (
  input wire logic clk,
  input wire logic resetn,
  tdr_link_if.dev lnk
);
  // ****************************************
  // parameter checks
  // ****************************************
  if (NCH < 1 || NCH > 256 || LAST_ADDR < 0 || LAST_ADDR > 63) begin : g_bad
    $error("tdr_dev: NCH or LAST_ADDR out of range");
  end

  localparam int MEM_D = 1 << (CHW + tdr_pkg::ADDR_W);
  localparam logic [tdr_pkg::ADDR_W-1:0] LAST = tdr_pkg::ADDR_W'(LAST_ADDR);
  localparam logic [tdr_pkg::CNT_W-1:0] CAL_LD = tdr_pkg::CNT_W'(tdr_pkg::CAL_CYC - 1);
  localparam logic [tdr_pkg::CNT_W-1:0] WORD_LD = tdr_pkg::CNT_W'(tdr_pkg::WORD_CYC - 1);
  localparam logic [tdr_pkg::CNT_W-1:0] ANA_LD = tdr_pkg::CNT_W'(tdr_pkg::ANA_CYC - 1);

  tdr_pkg::tdr_state_t st_r;
  tdr_pkg::tdr_state_t st_nxt;
  logic [tdr_pkg::CNT_W-1:0] cnt_r;
  logic cal_done_r;
  logic busy_r;
  logic [tdr_pkg::ADDR_W-1:0] addr_r;
  logic step_r;
  logic done_r;
  logic [tdr_pkg::WORD_W-1:0] word_r;
  logic [CHW-1:0] chan_r;
  logic [1:0] dir_r;
  logic [tdr_pkg::SWING_W-1:0] swing_l;
  logic [tdr_pkg::PRE_W-1:0] pre_l;
  logic [tdr_pkg::GAIN_W-1:0] gain_l;
  logic [tdr_pkg::EQ_W-1:0] eq_l;
  logic [tdr_pkg::WORD_W-1:0] mem_r [MEM_D];
  logic [tdr_pkg::SWING_W-1:0] sw_ch_r [NCH];
  logic [tdr_pkg::PRE_W-1:0] pre_ch_r [NCH];
  logic [tdr_pkg::GAIN_W-1:0] gain_ch_r [NCH];
  logic [tdr_pkg::EQ_W-1:0] eq_ch_r [NCH];
  logic [tdr_pkg::WORD_W-1:0] cfg_rb_r;
  logic [tdr_pkg::SWING_W-1:0] sw_rb_r;
  logic [tdr_pkg::PRE_W-1:0] pre_rb_r;
  logic [tdr_pkg::GAIN_W-1:0] gain_rb_r;
  logic [tdr_pkg::EQ_W-1:0] eq_rb_r;
  logic idle;
  logic go_word;
  logic go_ana;
  logic fin_word;
  logic fin_ana;
  logic cnt_zero;
  logic chan_ok;

  // ****************************************
  // sequencing
  // ****************************************
  // decode of the current step
  assign idle = (st_r == tdr_pkg::ST_IDLE);
  assign cnt_zero = (cnt_r == '0);
  assign go_word = idle & lnk.write_all & lnk.load_mode & ~lnk.ctrl_rst;
  assign go_ana = idle & lnk.write_all & ~lnk.load_mode & ~lnk.ctrl_rst;
  assign fin_word = (st_r == tdr_pkg::ST_WORD) & cnt_zero;
  assign fin_ana = (st_r == tdr_pkg::ST_ANA) & cnt_zero;
  assign chan_ok = (32'(lnk.chan_addr) < NCH);

  // next state
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      tdr_pkg::ST_CAL: begin
        if (cnt_zero) begin
          st_nxt = tdr_pkg::ST_IDLE;
        end
      end
      tdr_pkg::ST_IDLE: begin
        if (go_word) begin
          st_nxt = tdr_pkg::ST_WORD;
        end else if (go_ana) begin
          st_nxt = tdr_pkg::ST_ANA;
        end
      end
      tdr_pkg::ST_WORD: begin
        if (cnt_zero || lnk.ctrl_rst) begin
          st_nxt = tdr_pkg::ST_IDLE;
        end
      end
      tdr_pkg::ST_ANA: begin
        if (cnt_zero || lnk.ctrl_rst) begin
          st_nxt = tdr_pkg::ST_IDLE;
        end
      end
      default: st_nxt = tdr_pkg::ST_IDLE;
    endcase
  end

  // state register; power-up starts in cancellation
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= tdr_pkg::ST_CAL;
    end else begin
      st_r <= st_nxt;
    end
  end

  // duration counter
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= CAL_LD;
    end else if (lnk.ctrl_rst && st_r != tdr_pkg::ST_CAL) begin
      cnt_r <= '0;
    end else if (go_word) begin
      cnt_r <= WORD_LD;
    end else if (go_ana) begin
      cnt_r <= ANA_LD;
    end else if (!idle && !cnt_zero) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

  // cancellation happened once; only power-up reset clears it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cal_done_r <= 1'b0;
    end else if (st_r == tdr_pkg::ST_CAL && cnt_zero) begin
      cal_done_r <= 1'b1;
    end
  end

  // busy follows the next state, so it moves only on operations and at the end of cancellation
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      busy_r <= 1'b1;
    end else begin
      busy_r <= (st_nxt != tdr_pkg::ST_IDLE);
    end
  end

  // ****************************************
  // request capture
  // ****************************************
  // hold the request values for the whole write
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      word_r <= '0;
      chan_r <= '0;
      dir_r <= '0;
      swing_l <= '0;
      pre_l <= '0;
      gain_l <= '0;
      eq_l <= '0;
    end else if (lnk.ctrl_rst) begin
      word_r <= '0;
      chan_r <= '0;
      dir_r <= '0;
      swing_l <= '0;
      pre_l <= '0;
      gain_l <= '0;
      eq_l <= '0;
    end else if (go_word || go_ana) begin
      word_r <= lnk.cfg_data;
      chan_r <= lnk.chan_addr;
      dir_r <= lnk.dir_sel;
      swing_l <= lnk.swing;
      pre_l <= lnk.preemp;
      gain_l <= lnk.eq_gain;
      eq_l <= lnk.eq_ctrl;
    end
  end

  // ****************************************
  // word load progress
  // ****************************************
  // address counter with wrap and restart
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      addr_r <= '0;
    end else if (lnk.ctrl_rst || lnk.addr_rst) begin
      addr_r <= '0;
    end else if (fin_word) begin
      addr_r <= (addr_r == LAST) ? '0 : addr_r + 1'b1;
    end
  end

  // one-cycle strobe once a whole word is written
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      step_r <= 1'b0;
    end else begin
      step_r <= fin_word & ~lnk.ctrl_rst;
    end
  end

  // completion flag
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      done_r <= 1'b0;
    end else if (lnk.ctrl_rst) begin
      done_r <= 1'b0;
    end else if (fin_word && addr_r == LAST) begin
      done_r <= 1'b1;
    end else if (go_word && addr_r == '0) begin
      done_r <= 1'b0;
    end
  end

  // channel configuration store, indexed by channel and address
  always_ff @(posedge clk) begin
    if (fin_word && !lnk.ctrl_rst) begin
      mem_r[{chan_r, addr_r}] <= word_r;
    end
  end

  // ****************************************
  // per-channel analog controls
  // ****************************************
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    // only the addressed channel and chosen direction take the write
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        sw_ch_r[g] <= '0;
        pre_ch_r[g] <= '0;
        gain_ch_r[g] <= '0;
        eq_ch_r[g] <= '0;
      end else if (lnk.ctrl_rst) begin
        sw_ch_r[g] <= '0;
        pre_ch_r[g] <= '0;
        gain_ch_r[g] <= '0;
        eq_ch_r[g] <= '0;
      end else if (fin_ana && chan_r == CHW'(g)) begin
        if (dir_r[1]) begin
          sw_ch_r[g] <= swing_l;
          pre_ch_r[g] <= pre_l;
        end
        if (dir_r[0]) begin
          gain_ch_r[g] <= gain_l;
          eq_ch_r[g] <= eq_l;
        end
      end
    end
  end

  // readback of the channel on the address input
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cfg_rb_r <= '0;
      sw_rb_r <= '0;
      pre_rb_r <= '0;
      gain_rb_r <= '0;
      eq_rb_r <= '0;
    end else begin
      cfg_rb_r <= mem_r[{lnk.chan_addr, addr_r}];
      sw_rb_r <= chan_ok ? sw_ch_r[lnk.chan_addr] : '0;
      pre_rb_r <= chan_ok ? pre_ch_r[lnk.chan_addr] : '0;
      gain_rb_r <= chan_ok ? gain_ch_r[lnk.chan_addr] : '0;
      eq_rb_r <= chan_ok ? eq_ch_r[lnk.chan_addr] : '0;
    end
  end

  // outputs, all from flip-flops
  assign lnk.busy = busy_r;
  assign lnk.addr_out = addr_r;
  assign lnk.addr_step = step_r;
  assign lnk.load_done = done_r;
  assign lnk.cfg_rb = cfg_rb_r;
  assign lnk.swing_rb = sw_rb_r;
  assign lnk.preemp_rb = pre_rb_r;
  assign lnk.eq_gain_rb = gain_rb_r;
  assign lnk.eq_ctrl_rb = eq_rb_r;
endmodule

// *** tdr_pkg.sv ***
// tdr_pkg: shared constants and types for the transceiver reconfiguration controller
// assumes one 20 MHz clock shared by the device end and the user-logic end
package tdr_pkg;
  // ****************************************
  // clock and timing
  // ****************************************
  localparam int CLK_MHZ = 20;
  localparam int CAL_TIME_NS = 20000; // offset cancellation run
  localparam int WORD_TIME_NS = 400; // one 16-bit word into a channel
  localparam int ANA_TIME_NS = 600; // one analog control write
  localparam int CAL_CYC = (CAL_TIME_NS * CLK_MHZ / 1000) < 1 ? 1 : CAL_TIME_NS * CLK_MHZ / 1000;
  localparam int WORD_CYC = (WORD_TIME_NS * CLK_MHZ / 1000) < 1 ? 1 : WORD_TIME_NS * CLK_MHZ / 1000;
  localparam int ANA_CYC = (ANA_TIME_NS * CLK_MHZ / 1000) < 1 ? 1 : ANA_TIME_NS * CLK_MHZ / 1000;
  localparam int CNT_W = 16;

  // ****************************************
  // field widths
  // ****************************************
  localparam int ADDR_W = 6;
  localparam int WORD_W = 16;
  localparam int SWING_W = 3;
  localparam int PRE_W = 5;
  localparam int GAIN_W = 2;
  localparam int EQ_W = 4;
  localparam int LAST_ADDR_DEF = 63;

  // direction select codes
  localparam logic [1:0] DIR_RX = 2'h1;
  localparam logic [1:0] DIR_TX = 2'h2;
  localparam logic [1:0] DIR_BOTH = 2'h3;

  // device states, one-hot
  typedef enum logic [3:0] {
    ST_CAL = 4'h1,
    ST_IDLE = 4'h2,
    ST_WORD = 4'h4,
    ST_ANA = 4'h8
  } tdr_state_t;

  // ****************************************
  // user-logic register map (word index)
  // ****************************************
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_SET = 4'h1;
  localparam logic [3:0] REG_DATA = 4'h2;
  localparam logic [3:0] REG_STAT = 4'h3;
  localparam logic [3:0] REG_RB = 4'h4;
  localparam logic [3:0] REG_IRQ = 4'h5;
  localparam logic [3:0] REG_MASK = 4'h6;
  // command bits of REG_CTRL
  localparam int CTRL_ANA = 0;
  localparam int CTRL_WORD = 1;
  localparam int CTRL_ARST = 2;
  localparam int CTRL_CRST = 3;
  // field positions of REG_SET and REG_RB
  localparam int F_SWING = 0;
  localparam int F_PRE = 3;
  localparam int F_GAIN = 8;
  localparam int F_EQ = 10;
  localparam int F_DIR = 14;
  localparam int F_CHAN = 16;
  localparam int F_RBWORD = 16;
  // status bits
  localparam int S_BUSY = 0;
  localparam int S_DONE = 1;
  localparam int S_ADDR = 8;
  // interrupt bits
  localparam int I_STEP = 0;
  localparam int I_DONE = 1;
  localparam int I_IDLE = 2;
  localparam int IRQ_W = 3;
  localparam logic [IRQ_W-1:0] MASK_RST = 3'h0;
  localparam logic [31:0] SET_RST = 32'h0;
endpackage

// *** tdr_link_if.sv ***
// tdr_link_if: ports between the reconfiguration controller and user logic
// assumes both ends run on the same clock; no clocking block
interface tdr_link_if #(
  parameter int NCH = 4,
  parameter int CHW = (NCH > 1) ? $clog2(NCH) : 1
);
  // user logic to controller
  logic write_all;
  logic load_mode; // 1: configuration word, 0: analog controls
  logic addr_rst;
  logic ctrl_rst;
  logic [tdr_pkg::WORD_W-1:0] cfg_data;
  logic [CHW-1:0] chan_addr;
  logic [1:0] dir_sel;
  logic [tdr_pkg::SWING_W-1:0] swing;
  logic [tdr_pkg::PRE_W-1:0] preemp;
  logic [tdr_pkg::GAIN_W-1:0] eq_gain;
  logic [tdr_pkg::EQ_W-1:0] eq_ctrl;
  // controller to user logic
  logic busy;
  logic [tdr_pkg::ADDR_W-1:0] addr_out;
  logic addr_step;
  logic load_done;
  logic [tdr_pkg::WORD_W-1:0] cfg_rb;
  logic [tdr_pkg::SWING_W-1:0] swing_rb;
  logic [tdr_pkg::PRE_W-1:0] preemp_rb;
  logic [tdr_pkg::GAIN_W-1:0] eq_gain_rb;
  logic [tdr_pkg::EQ_W-1:0] eq_ctrl_rb;

  modport dev (
    input write_all, load_mode, addr_rst, ctrl_rst, cfg_data, chan_addr, dir_sel,
    input swing, preemp, eq_gain, eq_ctrl,
    output busy, addr_out, addr_step, load_done, cfg_rb,
    output swing_rb, preemp_rb, eq_gain_rb, eq_ctrl_rb
  );
  modport host (
    output write_all, load_mode, addr_rst, ctrl_rst, cfg_data, chan_addr, dir_sel,
    output swing, preemp, eq_gain, eq_ctrl,
    input busy, addr_out, addr_step, load_done, cfg_rb,
    input swing_rb, preemp_rb, eq_gain_rb, eq_ctrl_rb
  );
endinterface

// *** tdr_host.sv ***
// tdr_host: user-logic end of tdr_link_if, driven from a register port
// assumes software on the same clock; read data one cycle after read strobe
module tdr_host #(
  parameter int NCH = 4,
  parameter int CHW = (NCH > 1) ? $clog2(NCH) : 1
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq,
  tdr_link_if.host lnk
);
  // ****************************************
  // parameter checks
  // ****************************************
  if (NCH < 1 || NCH > 256) begin : g_bad
    $error("tdr_host: NCH out of range");
  end

  logic [31:0] set_r;
  logic [tdr_pkg::WORD_W-1:0] data_r;
  logic wa_r;
  logic mode_r;
  logic arst_r;
  logic crst_r;
  logic [tdr_pkg::IRQ_W-1:0] ist_r;
  logic [tdr_pkg::IRQ_W-1:0] msk_r;
  logic [tdr_pkg::IRQ_W-1:0] ev;
  logic busy_d_r;
  logic done_d_r;
  logic [31:0] rdata_r;
  logic irq_r;
  logic ctl_wr;
  logic can_go;
  logic [31:0] stat_v;
  logic [31:0] rb_v;

  assign ctl_wr = reg_wr & (reg_addr == tdr_pkg::REG_CTRL);
  // refuse a start while busy or while the last strobe is in flight
  assign can_go = ~lnk.busy & ~wa_r & ~crst_r;

  // ****************************************
  // settings and data
  // ****************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      set_r <= tdr_pkg::SET_RST;
      data_r <= '0;
    end else if (reg_wr && reg_addr == tdr_pkg::REG_SET) begin
      set_r <= reg_wdata;
    end else if (reg_wr && reg_addr == tdr_pkg::REG_DATA) begin
      data_r <= reg_wdata[tdr_pkg::WORD_W-1:0];
    end
  end

  // one-cycle strobes and the held load mode toward the controller
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wa_r <= 1'b0;
      mode_r <= 1'b0;
      arst_r <= 1'b0;
      crst_r <= 1'b0;
    end else begin
      wa_r <= ctl_wr & can_go & (reg_wdata[tdr_pkg::CTRL_ANA] | reg_wdata[tdr_pkg::CTRL_WORD]);
      if (ctl_wr && can_go) begin
        mode_r <= reg_wdata[tdr_pkg::CTRL_WORD];
      end
      arst_r <= ctl_wr & reg_wdata[tdr_pkg::CTRL_ARST];
      crst_r <= ctl_wr & reg_wdata[tdr_pkg::CTRL_CRST];
    end
  end

  // ****************************************
  // interrupts
  // ****************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      busy_d_r <= 1'b0;
      done_d_r <= 1'b0;
    end else begin
      busy_d_r <= lnk.busy;
      done_d_r <= lnk.load_done;
    end
  end
  assign ev[tdr_pkg::I_STEP] = lnk.addr_step;
  assign ev[tdr_pkg::I_DONE] = lnk.load_done & ~done_d_r;
  assign ev[tdr_pkg::I_IDLE] = busy_d_r & ~lnk.busy;

  // sticky status, write one to clear, set wins
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ist_r <= '0;
      msk_r <= tdr_pkg::MASK_RST;
      irq_r <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == tdr_pkg::REG_IRQ) begin
        ist_r <= (ist_r & ~reg_wdata[tdr_pkg::IRQ_W-1:0]) | ev;
      end else begin
        ist_r <= ist_r | ev;
      end
      if (reg_wr && reg_addr == tdr_pkg::REG_MASK) begin
        msk_r <= reg_wdata[tdr_pkg::IRQ_W-1:0];
      end
      irq_r <= |(ist_r & msk_r);
    end
  end

  // ****************************************
  // read port
  // ****************************************
  always_comb begin
    stat_v = '0;
    stat_v[tdr_pkg::S_BUSY] = lnk.busy;
    stat_v[tdr_pkg::S_DONE] = lnk.load_done;
    stat_v[tdr_pkg::S_ADDR +: tdr_pkg::ADDR_W] = lnk.addr_out;
    rb_v = '0;
    rb_v[tdr_pkg::F_SWING +: tdr_pkg::SWING_W] = lnk.swing_rb;
    rb_v[tdr_pkg::F_PRE +: tdr_pkg::PRE_W] = lnk.preemp_rb;
    rb_v[tdr_pkg::F_GAIN +: tdr_pkg::GAIN_W] = lnk.eq_gain_rb;
    rb_v[tdr_pkg::F_EQ +: tdr_pkg::EQ_W] = lnk.eq_ctrl_rb;
    rb_v[tdr_pkg::F_RBWORD +: tdr_pkg::WORD_W] = lnk.cfg_rb;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_r <= '0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        tdr_pkg::REG_SET: rdata_r <= set_r;
        tdr_pkg::REG_DATA: rdata_r <= 32'(data_r);
        tdr_pkg::REG_STAT: rdata_r <= stat_v;
        tdr_pkg::REG_RB: rdata_r <= rb_v;
        tdr_pkg::REG_IRQ: rdata_r <= 32'(ist_r);
        tdr_pkg::REG_MASK: rdata_r <= 32'(msk_r);
        default: rdata_r <= '0;
      endcase
    end else begin
      rdata_r <= '0;
    end
  end

  // link outputs, from flip-flops
  assign lnk.write_all = wa_r;
  assign lnk.load_mode = mode_r;
  assign lnk.addr_rst = arst_r;
  assign lnk.ctrl_rst = crst_r;
  assign lnk.cfg_data = data_r;
  assign lnk.chan_addr = set_r[tdr_pkg::F_CHAN +: CHW];
  assign lnk.dir_sel = set_r[tdr_pkg::F_DIR +: 2];
  assign lnk.swing = set_r[tdr_pkg::F_SWING +: tdr_pkg::SWING_W];
  assign lnk.preemp = set_r[tdr_pkg::F_PRE +: tdr_pkg::PRE_W];
  assign lnk.eq_gain = set_r[tdr_pkg::F_GAIN +: tdr_pkg::GAIN_W];
  assign lnk.eq_ctrl = set_r[tdr_pkg::F_EQ +: tdr_pkg::EQ_W];
  assign reg_rdata = rdata_r;
  assign irq = irq_r;
endmodule

// *** tdr_checker.sv ***
// tdr_checker: timing assertions on the link between tdr_dev and tdr_host
// assumes one clock domain; inputs are plain copies of tdr_link_if signals
module tdr_checker #(
  parameter int LAST_ADDR = tdr_pkg::LAST_ADDR_DEF
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic write_all,
  input wire logic load_mode,
  input wire logic addr_rst,
  input wire logic ctrl_rst,
  input wire logic busy,
  input wire logic [tdr_pkg::ADDR_W-1:0] addr_out,
  input wire logic addr_step,
  input wire logic load_done
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  logic [9:0] cal_cnt_r;
  logic cal_seen_r;
  wire take_w = write_all && !busy && !ctrl_rst;
  // count busy cycles of the power-up cancellation run
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cal_cnt_r <= 10'h0;
      cal_seen_r <= 1'b0;
    end else if (!cal_seen_r) begin
      if (busy) begin
        cal_cnt_r <= cal_cnt_r + 10'h1;
      end else begin
        cal_seen_r <= 1'b1;
      end
    end
  end
  sequence s_word_run; busy [*8] ##1 (!busy && addr_step); endsequence
  sequence s_ana_run; busy [*8] ##1 busy [*4] ##1 !busy; endsequence
  // a controller reset may cut a run short
  property p_word;
    disable iff (!resetn || ctrl_rst) take_w && load_mode |=> s_word_run;
  endproperty
  property p_ana;
    disable iff (!resetn || ctrl_rst) take_w && !load_mode |=> s_ana_run;
  endproperty
  property p_start_idle; write_all |-> !busy; endproperty
  property p_one_shot; write_all |=> !write_all; endproperty
  property p_step;
    addr_step && ($past(addr_out) != 6'(LAST_ADDR)) |-> addr_out == $past(addr_out) + 6'h1;
  endproperty
  property p_wrap;
    addr_step && ($past(addr_out) == 6'(LAST_ADDR)) |-> addr_out == 6'h0 && load_done;
  endproperty
  property p_hold; !addr_step && !$past(addr_rst) && !$past(ctrl_rst) |-> $stable(addr_out);
  endproperty
  property p_restart; addr_rst |=> addr_out == 6'h0; endproperty
  property p_clear; ctrl_rst |=> addr_out == 6'h0 && !load_done && !addr_step; endproperty
  property p_done_drop; take_w && load_mode && addr_out == 6'h0 |=> !load_done; endproperty
  property p_quiet; !busy && !write_all |=> !busy; endproperty
  property p_cal; !cal_seen_r && !busy |-> cal_cnt_r == 10'(tdr_pkg::CAL_CYC);
  endproperty
  a_word: assert property (p_word) else $error("word write span wrong");
  a_ana: assert property (p_ana) else $error("analog write span wrong");
  a_step: assert property (p_step) else $error("address did not step by one");
  a_wrap: assert property (p_wrap) else $error("no wrap with done");
  a_hold: assert property (p_hold) else $error("address moved without step");
  a_restart: assert property (p_restart) else $error("address restart missed");
  a_clear: assert property (p_clear) else $error("controller reset incomplete");
  a_done_drop: assert property (p_done_drop) else $error("done not dropped");
  a_quiet: assert property (p_quiet) else $error("busy rose unprompted");
  a_cal: assert property (p_cal) else $error("cancellation length wrong");
  a_start_idle: assert property (p_start_idle) else $error("start raised while busy");
  a_one_shot: assert property (p_one_shot) else $error("write strobe too long");
endmodule

// *** transceiver_dynamic_reconfig_ctrl_bench.sv ***
// transceiver_dynamic_reconfig_ctrl_bench: host and device joined over tdr_link_if
// assumes register port of tdr_host; read data checked from a queue of notes
module transceiver_dynamic_reconfig_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int LAST = 3;
  typedef struct {string name; logic [31:0] exp; logic [31:0] msk;} tdr_note_t;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic irq;
  logic rd_d = 1'b0;
  logic [31:0] seed = 32'hF95D42C6;
  logic [31:0] v;
  logic [1:0] ch;
  logic [15:0] w0;
  logic [13:0] ch_m [4] = '{default: 14'h0};
  int errors = 0;
  int compares = 0;
  tdr_note_t note_q [$];
  tdr_note_t mon_n;

  always #25 clk = ~clk;
  tdr_link_if lnk ();
  tdr_dev #(.LAST_ADDR(LAST)) tdr_dev_i (.clk(clk), .resetn(resetn), .lnk(lnk));
  tdr_host tdr_host_i (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .lnk(lnk));
  tdr_checker #(.LAST_ADDR(LAST)) tdr_checker_i (.clk(clk), .resetn(resetn),
    .write_all(lnk.write_all), .load_mode(lnk.load_mode), .addr_rst(lnk.addr_rst),
    .ctrl_rst(lnk.ctrl_rst), .busy(lnk.busy), .addr_out(lnk.addr_out),
    .addr_step(lnk.addr_step), .load_done(lnk.load_done));

  task results();
    $display("checks %0d mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input string name, input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    note_q.push_back('{name, e, m});
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask
  task idle();
    int n;
    n = 0;
    repeat (3) @(posedge clk);
    while (lnk.busy !== 1'b0 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    chk("busy settles", {31'h0, lnk.busy}, 32'h0);
    @(posedge clk);
  endtask

  // read data answer one cycle after the strobe
  always @(posedge clk) begin
    rd_d <= reg_rd;
    if (rd_d === 1'b1 && note_q.size() > 0) begin
      mon_n = note_q.pop_front();
      chk(mon_n.name, reg_rdata & mon_n.msk, mon_n.exp & mon_n.msk);
    end
  end

  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    $display("watchdog expired");
    results();
  end

  // main sequence
  initial begin
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    rd("stat cal", tdr_pkg::REG_STAT, 32'h1, 32'h3F03);
    wr(tdr_pkg::REG_CTRL, 32'h8);
    idle();
    rd("stat idle", tdr_pkg::REG_STAT, 32'h0, 32'h3F03);
    rd("mask rst", tdr_pkg::REG_MASK, 32'h0, 32'hFFFFFFFF);
    rd("unmapped", 4'h9, 32'h0, 32'hFFFFFFFF);
    rd("irq cal", tdr_pkg::REG_IRQ, 32'h4, 32'h7);
    wr(tdr_pkg::REG_MASK, 32'h4);
    repeat (3) @(posedge clk);
    chk("irq high", {31'h0, irq}, 32'h1);
    wr(tdr_pkg::REG_IRQ, 32'h4);
    repeat (3) @(posedge clk);
    chk("irq low", {31'h0, irq}, 32'h0);
    $display("test power-up done");
    for (int i = 0; i < 8; i++) begin
      v = rnd();
      ch = v[17:16];
      wr(tdr_pkg::REG_SET, {14'h0, ch, i[1:0], v[13:0]});
      wr(tdr_pkg::REG_CTRL, 32'h1);
      repeat (4) @(posedge clk);
      wr(tdr_pkg::REG_CTRL, 32'h1);
      idle();
      if (i[1]) ch_m[ch][7:0] = v[7:0];
      if (i[0]) ch_m[ch][13:8] = v[13:8];
      rd("rb chan", tdr_pkg::REG_RB, {18'h0, ch_m[ch]}, 32'h3FFF);
      wr(tdr_pkg::REG_SET, {14'h0, ch + 2'h1, 16'h0});
      rd("rb other", tdr_pkg::REG_RB, {18'h0, ch_m[ch + 2'h1]}, 32'h3FFF);
    end
    $display("test analog done");
    wr(tdr_pkg::REG_SET, 32'h10000);
    for (int i = 0; i <= LAST; i++) begin
      v = rnd();
      if (i == 0) w0 = v[15:0];
      wr(tdr_pkg::REG_DATA, {16'h0, v[15:0]});
      wr(tdr_pkg::REG_CTRL, 32'h2);
      idle();
      rd("stat step", tdr_pkg::REG_STAT, {18'h0, 6'((i + 1) % (LAST + 1)), 6'h0, i == LAST, 1'b0},
        32'h3F03);
    end
    rd("word stored", tdr_pkg::REG_RB, {w0, 16'h0}, 32'hFFFF0000);
    rd("irq events", tdr_pkg::REG_IRQ, 32'h7, 32'h7);
    wr(tdr_pkg::REG_MASK, 32'h0);
    repeat (3) @(posedge clk);
    chk("irq masked", {31'h0, irq}, 32'h0);
    wr(tdr_pkg::REG_MASK, 32'h2);
    repeat (3) @(posedge clk);
    chk("irq done", {31'h0, irq}, 32'h1);
    wr(tdr_pkg::REG_IRQ, 32'h7);
    repeat (3) @(posedge clk);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    $display("test load done");
    wr(tdr_pkg::REG_DATA, rnd() & 32'hFFFF);
    wr(tdr_pkg::REG_CTRL, 32'h2);
    repeat (3) @(posedge clk);
    rd("done drop", tdr_pkg::REG_STAT, 32'h1, 32'h3F03);
    idle();
    rd("next addr", tdr_pkg::REG_STAT, 32'h100, 32'h3F03);
    wr(tdr_pkg::REG_CTRL, 32'h8);
    repeat (2) @(posedge clk);
    rd("ctrl reset", tdr_pkg::REG_STAT, 32'h0, 32'h3F03);
    for (int c = 0; c < 4; c++) begin
      wr(tdr_pkg::REG_SET, {14'h0, c[1:0], 16'h0});
      rd("rb cleared", tdr_pkg::REG_RB, 32'h0, 32'h3FFF);
    end
    wr(tdr_pkg::REG_CTRL, 32'h2);
    idle();
    wr(tdr_pkg::REG_CTRL, 32'h4);
    repeat (2) @(posedge clk);
    rd("addr restart", tdr_pkg::REG_STAT, 32'h0, 32'h3F03);
    wr(tdr_pkg::REG_CTRL, 32'h2);
    repeat (2) @(posedge clk);
    wr(tdr_pkg::REG_CTRL, 32'h8);
    repeat (2) @(posedge clk);
    rd("abort", tdr_pkg::REG_STAT, 32'h0, 32'h3F03);
    repeat (20) @(posedge clk);
    rd("no recal", tdr_pkg::REG_STAT, 32'h0, 32'h3F03);
    repeat (3) @(posedge clk);
    $display("test reset done");
    results();
  end
endmodule
